/* File: common/mrcr_pkg.sv */
package mrcr_pkg;
	// ----------------------------------------
	// bus and map geometry
	// ----------------------------------------
	localparam int          MRCR_ADDR_W     = 8;
	localparam int          MRCR_DATA_W     = 8;
	localparam int          MRCR_NUM_REGS   = 12;
	localparam int          MRCR_IDX_W      = 4;
	localparam logic [7:0]  MRCR_OFS_REG_CTRL_A   = 8'h0E;
	localparam logic [7:0]  MRCR_OFS_SETPOINT     = 8'h0F;
	localparam logic [7:0]  MRCR_OFS_FILTER_DUTY  = 8'h10;
	localparam logic [7:0]  MRCR_OFS_LOOP_RSV_A   = 8'h11;
	localparam logic [7:0]  MRCR_OFS_LOOP_RSV_B   = 8'h12;
	localparam logic [7:0]  MRCR_OFS_PARAM_SCALE  = 8'h13;
	localparam logic [7:0]  MRCR_OFS_INV_RES      = 8'h14;
	localparam logic [7:0]  MRCR_OFS_BACK_EMF     = 8'h15;
	localparam logic [7:0]  MRCR_OFS_LOOP_RSV_C   = 8'h16;
	localparam logic [7:0]  MRCR_OFS_LOOP_RSV_D   = 8'h17;
	localparam logic [7:0]  MRCR_OFS_PROP_GAIN    = 8'h18;
	localparam logic [7:0]  MRCR_OFS_INT_GAIN     = 8'h19;
	// ----------------------------------------
	// reset values and writable bits, by index
	// ----------------------------------------
	localparam logic [7:0] MRCR_RESET [MRCR_NUM_REGS] = '{
		8'h27, 8'hFF, 8'h00, 8'h01, 8'hFF, 8'h73,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h21, 8'h21};
	localparam logic [7:0] MRCR_WMASK [MRCR_NUM_REGS] = '{
		8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
		8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int MRCR_SOFT_EN_BIT      = 5;
	localparam int MRCR_SCHEME_LSB       = 3;
	localparam int MRCR_PWM_RATE_BIT     = 2;
	localparam int MRCR_SPEED_SCALE_LSB  = 0;
	localparam int MRCR_FILTER_LSB       = 6;
	localparam int MRCR_DUTY_LSB         = 0;
	localparam int MRCR_RES_SCALE_LSB    = 6;
	localparam int MRCR_BEMF_SCALE_LSB   = 4;
	localparam int MRCR_DUTY_W           = 6;
	localparam logic [5:0] MRCR_DUTY_FULL = 6'h3F;
	// ----------------------------------------
	// regulation schemes
	// ----------------------------------------
	typedef enum logic [1:0] {
		MRCR_FIXED_OFF_TIME = 2'b00,
		MRCR_CYCLE_BY_CYCLE = 2'b01,
		MRCR_SPEED_REG      = 2'b10,
		MRCR_VOLTAGE_REG    = 2'b11
	} mrcr_scheme_t;
	// ----------------------------------------
	// decode tables, indexed by field code
	// ----------------------------------------
	localparam logic [7:0]  MRCR_SPEED_SCALE [4] = '{8'd16, 8'd32, 8'd64, 8'd128};
	localparam logic [10:0] MRCR_FILTER_HZ [4] = '{11'd250, 11'd500, 11'd750, 11'd1000};
	localparam logic [13:0] MRCR_RES_SCALE [4] = '{14'd2, 14'd64, 14'd1024, 14'd8192};
	localparam logic [17:0] MRCR_BEMF_SCALE [4] = '{
		18'd24 << 8, 18'd24 << 9, 18'd24 << 12, 18'd24 << 13};
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int          MRCR_CLK_HZ        = 100_000_000;
	localparam int          MRCR_CLK_MHZ       = 100;
	localparam int          MRCR_PWM_FAST_HZ   = 50_000;
	localparam int          MRCR_PWM_SLOW_HZ   = 25_000;
	localparam logic [11:0] MRCR_PWM_FAST_CYC  = 12'(MRCR_CLK_HZ / MRCR_PWM_FAST_HZ);
	localparam logic [11:0] MRCR_PWM_SLOW_CYC  = 12'(MRCR_CLK_HZ / MRCR_PWM_SLOW_HZ);
	localparam int          MRCR_INRUSH_US_DEF = 1000;
	localparam int          MRCR_RAMP_STEPS    = 256;
endpackage : mrcr_pkg

/* File: logic/mrcr_regmem.sv */
`timescale 1ns/10ps
`default_nettype none
module mrcr_regmem
	import mrcr_pkg::*;
(
	// clock and reset
	input  wire logic                                  clk,
	input  wire logic                                  rst_n,
	// access
	input  wire logic                                  wr_en,
	input  wire logic                                  rd_en,
	input  wire logic [mrcr_pkg::MRCR_IDX_W-1:0]       idx,
	input  wire logic [mrcr_pkg::MRCR_DATA_W-1:0]      wdata,
	output logic      [mrcr_pkg::MRCR_DATA_W-1:0]      rdata_q,
	// contents
	output logic      [mrcr_pkg::MRCR_NUM_REGS*8-1:0]  regs_flat
);
	import mrcr_pkg::*;

	logic [7:0] regs_q [MRCR_NUM_REGS];
	logic       idx_ok;

	assign idx_ok = (idx < 4'(MRCR_NUM_REGS));

	// ----------------------------------------
	// storage, one byte per entry
	// ----------------------------------------
	for (genvar i = 0; i < MRCR_NUM_REGS; i++)
	begin : g_entry
		always_ff @(posedge clk or negedge rst_n)
		begin
			if (!rst_n)
				regs_q[i] <= MRCR_RESET[i];
			else if (wr_en && idx == 4'(i))
				regs_q[i] <= wdata & MRCR_WMASK[i];
		end
		assign regs_flat[i*8 +: 8] = regs_q[i];
	end

	// ----------------------------------------
	// registered read port
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rdata_q <= 8'h00;
		else if (rd_en)
			rdata_q <= idx_ok ? regs_q[idx] : 8'h00;
	end
endmodule : mrcr_regmem
`default_nettype wire

/* File: logic/mrcr_top.sv */
`timescale 1ns/10ps
`default_nettype none
module mrcr_top
	import mrcr_pkg::*;
#(
	parameter int INRUSH_US = mrcr_pkg::MRCR_INRUSH_US_DEF
)
(
	// clock and reset
	input  wire logic                              clk,
	input  wire logic                              rst_n,
	// register port from the serial front end
	input  wire logic                              reg_wr_en,
	input  wire logic                              reg_rd_en,
	input  wire logic [mrcr_pkg::MRCR_ADDR_W-1:0]  reg_addr,
	input  wire logic [mrcr_pkg::MRCR_DATA_W-1:0]  reg_wdata,
	output logic      [mrcr_pkg::MRCR_DATA_W-1:0]  reg_rdata,
	output logic                                   reg_rd_valid,
	// bridge command controls
	input  wire logic                              bridge_command_source,
	input  wire logic                              bridge_enable_pwm_bit,
	input  wire logic                              bridge_phase_pwm_bit,
	input  wire logic                              duty_ctrl,
	input  wire logic [1:0]                        bridge_input_pins,
	// bridge drive
	output logic                                   bridge_in1,
	output logic                                   bridge_in2,
	output logic                                   internal_pwm_active,
	// regulation settings
	output mrcr_pkg::mrcr_scheme_t                 scheme,
	output logic      [7:0]                        speed_voltage_setpoint,
	output logic                                   ramp_busy,
	output logic      [7:0]                        speed_scale_factor,
	output logic      [10:0]                       output_filter_cutoff,
	output logic      [13:0]                       resistance_param_scale,
	output logic      [17:0]                       back_emf_param_scale,
	output logic      [7:0]                        inverse_resistance_param,
	output logic      [7:0]                        back_emf_param
);
	import mrcr_pkg::*;

	localparam int          STEP_CYC_I = (INRUSH_US * MRCR_CLK_MHZ) / MRCR_RAMP_STEPS;
	localparam logic [23:0] STEP_CYC   = 24'((STEP_CYC_I < 1) ? 1 : STEP_CYC_I);

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	logic                          addr_hit;
	logic [MRCR_ADDR_W-1:0]        addr_rel;
	logic [MRCR_IDX_W-1:0]         reg_idx;
	logic                          wr_go;
	logic                          rd_go;
	logic [MRCR_NUM_REGS*8-1:0]    regs_flat;
	logic [MRCR_IDX_W-1:0]         mem_idx;

	assign addr_hit = (reg_addr >= MRCR_OFS_REG_CTRL_A) && (reg_addr <= MRCR_OFS_INT_GAIN);
	assign addr_rel = reg_addr - MRCR_OFS_REG_CTRL_A;
	assign reg_idx  = addr_rel[MRCR_IDX_W-1:0];
	// writes outside the map are dropped
	assign wr_go    = reg_wr_en && addr_hit;
	assign rd_go    = reg_rd_en;
	assign mem_idx  = addr_hit ? reg_idx : 4'hF;

	mrcr_regmem u_mem (
		.clk       (clk),
		.rst_n     (rst_n),
		.wr_en     (wr_go),
		.rd_en     (rd_go),
		.idx       (mem_idx),
		.wdata     (reg_wdata),
		.rdata_q   (reg_rdata),
		.regs_flat (regs_flat)
	);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rd_valid <= 1'b0;
		else
			reg_rd_valid <= rd_go;
	end

	// ----------------------------------------
	// field extraction
	// ----------------------------------------
	function automatic logic [7:0] reg_at(input logic [7:0] ofs,
		input logic [MRCR_NUM_REGS*8-1:0] flat);
		logic [7:0] rel;
		rel = ofs - MRCR_OFS_REG_CTRL_A;
		return flat[rel*8 +: 8];
	endfunction : reg_at

	logic [7:0]   ctrl_a;
	logic [7:0]   setpoint_reg;
	logic [7:0]   filt_duty;
	logic [7:0]   pscale;
	logic         soft_en;
	logic         rate_slow;
	logic [1:0]   scheme_code;
	logic [1:0]   speed_code;
	logic [1:0]   filt_code;
	logic [1:0]   res_code;
	logic [1:0]   bemf_code;
	logic [5:0]   duty;
	logic         regulating;

	assign ctrl_a       = reg_at(MRCR_OFS_REG_CTRL_A, regs_flat);
	assign setpoint_reg = reg_at(MRCR_OFS_SETPOINT, regs_flat);
	assign filt_duty    = reg_at(MRCR_OFS_FILTER_DUTY, regs_flat);
	assign pscale       = reg_at(MRCR_OFS_PARAM_SCALE, regs_flat);
	assign soft_en      = ctrl_a[MRCR_SOFT_EN_BIT];
	assign rate_slow    = ctrl_a[MRCR_PWM_RATE_BIT];
	assign scheme_code  = ctrl_a[MRCR_SCHEME_LSB +: 2];
	assign speed_code   = ctrl_a[MRCR_SPEED_SCALE_LSB +: 2];
	assign filt_code    = filt_duty[MRCR_FILTER_LSB +: 2];
	assign duty         = filt_duty[MRCR_DUTY_LSB +: MRCR_DUTY_W];
	assign res_code     = pscale[MRCR_RES_SCALE_LSB +: 2];
	assign bemf_code    = pscale[MRCR_BEMF_SCALE_LSB +: 2];
	assign regulating   = (scheme_code == MRCR_SPEED_REG) || (scheme_code == MRCR_VOLTAGE_REG);

	// ----------------------------------------
	// pin synchroniser
	// ----------------------------------------
	logic [1:0] pins_meta_q;
	logic [1:0] pins_sync_q;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pins_meta_q <= 2'b00;
			pins_sync_q <= 2'b00;
		end
		else
		begin
			pins_meta_q <= bridge_input_pins;
			pins_sync_q <= pins_meta_q;
		end
	end

	// ----------------------------------------
	// soft start and stop ramp
	// ----------------------------------------
	logic        run;
	logic [7:0]  target;
	logic [23:0] step_cnt_q;
	logic        step_tick;
	logic [7:0]  ramp_q;
	logic [7:0]  ramp_d;

	assign run       = bridge_command_source ? bridge_enable_pwm_bit : (pins_sync_q != 2'b00);
	assign target    = run ? setpoint_reg : 8'h00;
	assign step_tick = (step_cnt_q == STEP_CYC - 24'h000001);
	assign ramp_d    = !soft_en ? target :
		!step_tick ? ramp_q :
		(ramp_q < target) ? ramp_q + 8'h01 :
		(ramp_q > target) ? ramp_q - 8'h01 : ramp_q;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			step_cnt_q <= 24'h000000;
		else if (step_tick || !soft_en)
			step_cnt_q <= 24'h000000;
		else
			step_cnt_q <= step_cnt_q + 24'h000001;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			ramp_q <= 8'h00;
		else
			ramp_q <= ramp_d;
	end

	// ----------------------------------------
	// internal PWM generator
	// ----------------------------------------
	logic [11:0] period;
	logic [11:0] pwm_cnt_q;
	logic        pwm_wrap;
	logic [17:0] cnt_scaled;
	logic [17:0] duty_scaled;
	logic        pwm_on;
	logic        duty_mode;

	assign period      = rate_slow ? MRCR_PWM_SLOW_CYC : MRCR_PWM_FAST_CYC;
	assign pwm_wrap    = (pwm_cnt_q >= period - 12'h001);
	assign cnt_scaled  = {6'h00, pwm_cnt_q} * 18'(MRCR_DUTY_FULL);
	assign duty_scaled = {12'h000, duty} * {6'h00, period};
	// 0 never high, full code always high
	assign pwm_on      = cnt_scaled < duty_scaled;
	assign duty_mode   = bridge_command_source && !regulating && duty_ctrl;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			pwm_cnt_q <= 12'h000;
		else if (pwm_wrap)
			pwm_cnt_q <= 12'h000;
		else
			pwm_cnt_q <= pwm_cnt_q + 12'h001;
	end

	// ----------------------------------------
	// bridge command selection
	// ----------------------------------------
	logic in1_d;
	logic in2_d;

	assign in1_d = bridge_command_source ?
		(bridge_enable_pwm_bit && (!duty_mode || pwm_on)) : pins_sync_q[0];
	assign in2_d = bridge_command_source ? bridge_phase_pwm_bit : pins_sync_q[1];

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bridge_in1          <= 1'b0;
			bridge_in2          <= 1'b0;
			internal_pwm_active <= 1'b0;
		end
		else
		begin
			bridge_in1          <= in1_d;
			bridge_in2          <= in2_d;
			internal_pwm_active <= duty_mode;
		end
	end

	// ----------------------------------------
	// decoded next values
	// ----------------------------------------
	mrcr_scheme_t scheme_d;
	logic         ramp_busy_d;
	logic [7:0]   speed_scale_d;
	logic [10:0]  filter_cutoff_d;
	logic [13:0]  res_scale_d;
	logic [17:0]  bemf_scale_d;
	logic [7:0]   inv_res_d;
	logic [7:0]   bemf_param_d;

	assign scheme_d        = mrcr_scheme_t'(scheme_code);
	assign ramp_busy_d     = (ramp_q != target);
	assign speed_scale_d   = MRCR_SPEED_SCALE[speed_code];
	assign filter_cutoff_d = MRCR_FILTER_HZ[filt_code];
	assign res_scale_d     = MRCR_RES_SCALE[res_code];
	assign bemf_scale_d    = MRCR_BEMF_SCALE[bemf_code];
	assign inv_res_d       = reg_at(MRCR_OFS_INV_RES, regs_flat);
	assign bemf_param_d    = reg_at(MRCR_OFS_BACK_EMF, regs_flat);

	// ----------------------------------------
	// decoded settings
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			scheme                 <= MRCR_FIXED_OFF_TIME;
			speed_voltage_setpoint <= 8'h00;
			ramp_busy              <= 1'b0;
		end
		else
		begin
			scheme                 <= scheme_d;
			speed_voltage_setpoint <= ramp_q;
			ramp_busy              <= ramp_busy_d;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			speed_scale_factor     <= 8'h00;
			output_filter_cutoff   <= 11'h000;
			resistance_param_scale <= 14'h0000;
			back_emf_param_scale   <= 18'h00000;
		end
		else
		begin
			speed_scale_factor     <= speed_scale_d;
			output_filter_cutoff   <= filter_cutoff_d;
			resistance_param_scale <= res_scale_d;
			back_emf_param_scale   <= bemf_scale_d;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			inverse_resistance_param <= 8'h00;
			back_emf_param           <= 8'h00;
		end
		else
		begin
			inverse_resistance_param <= inv_res_d;
			back_emf_param           <= bemf_param_d;
		end
	end
endmodule : mrcr_top
`default_nettype wire

/* File: bench/mrcr_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module mrcr_properties
	import mrcr_pkg::*;
#(
	parameter int INRUSH_US = 1000
)
(
	// clock and reset
	input wire logic                   clk,
	input wire logic                   rst_n,
	// register port
	input wire logic                   reg_wr_en,
	input wire logic                   reg_rd_en,
	input wire logic [7:0]             reg_addr,
	input wire logic [7:0]             reg_wdata,
	input wire logic [7:0]             reg_rdata,
	// bridge
	input wire logic                   bridge_command_source,
	input wire logic                   bridge_enable_pwm_bit,
	input wire logic                   bridge_phase_pwm_bit,
	input wire logic                   duty_ctrl,
	input wire logic [1:0]             bridge_input_pins,
	input wire logic                   bridge_in1,
	input wire logic                   bridge_in2,
	// decoded settings
	input wire mrcr_pkg::mrcr_scheme_t scheme,
	input wire logic [7:0]             speed_scale_factor,
	input wire logic [10:0]            output_filter_cutoff,
	input wire logic [13:0]            resistance_param_scale,
	input wire logic [17:0]            back_emf_param_scale
);
	import mrcr_pkg::*;

	logic [7:0] wd1_q;
	logic [7:0] wd2_q;
	logic       w0e;
	logic       w10;
	logic       w13;
	assign w0e = reg_wr_en && reg_addr == 8'h0E;
	assign w10 = reg_wr_en && reg_addr == 8'h10;
	assign w13 = reg_wr_en && reg_addr == 8'h13;
	// write data as it was two edges back
	always_ff @(posedge clk)
	begin
		wd1_q <= reg_wdata;
		wd2_q <= wd1_q;
	end
	default clocking dcb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_unmapped_zero: assert property (
		reg_rd_en && (reg_addr < 8'h0E || reg_addr > 8'h19) |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_scheme_decode: assert property (
		w0e ##1 !w0e |=> scheme == wd2_q[4:3])
		else $error("scheme decode wrong");
	a_speed_scale: assert property (
		w0e ##1 !w0e |=> speed_scale_factor == 8'h10 << wd2_q[1:0])
		else $error("speed scale wrong");
	a_filter_cutoff: assert property (
		w10 ##1 !w10 |=> output_filter_cutoff == 11'd250 * (wd2_q[7:6] + 11'h1))
		else $error("filter cutoff wrong");
	a_res_scale: assert property (
		w13 ##1 !w13 |=> resistance_param_scale == (wd2_q[7] ?
		(wd2_q[6] ? 14'h2000 : 14'h400) : (wd2_q[6] ? 14'h40 : 14'h2)))
		else $error("resistance scale wrong");
	a_bemf_scale: assert property (
		w13 ##1 !w13 |=> back_emf_param_scale == 18'h18 << ({wd2_q[5], 1'b0, wd2_q[4]} + 4'h8))
		else $error("back-emf scale wrong");
	a_reg_bridge: assert property (
		bridge_command_source && !duty_ctrl |=> bridge_in1 == $past(bridge_enable_pwm_bit)
		&& bridge_in2 == $past(bridge_phase_pwm_bit))
		else $error("register bridge drive wrong");
	a_pin_bridge: assert property (
		!bridge_command_source [*4] |-> {bridge_in2, bridge_in1} == $past(bridge_input_pins, 3))
		else $error("pin bridge drive wrong");
endmodule : mrcr_properties
bind mrcr_top mrcr_properties #(.INRUSH_US(INRUSH_US)) u_props (.clk, .rst_n, .reg_wr_en,
	.reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .bridge_command_source,
	.bridge_enable_pwm_bit, .bridge_phase_pwm_bit, .duty_ctrl, .bridge_input_pins, .bridge_in1,
	.bridge_in2, .scheme, .speed_scale_factor, .output_filter_cutoff, .resistance_param_scale,
	.back_emf_param_scale);
`default_nettype wire

/* File: bench/mrcr_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module mrcr_host_model
(
	// clock
	input wire logic        clk,
	// register port
	output logic            reg_wr_en,
	output logic            reg_rd_en,
	output logic [7:0]      reg_addr,
	output logic [7:0]      reg_wdata,
	input wire logic [7:0]  reg_rdata,
	input wire logic        reg_rd_valid
);
	initial
	begin
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// every filter code sits at least twenty-five-fold below both rates
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = (a == 8'h14 && d == 8'h00) ? 8'h01 : d;
		if (a >= 8'h0E && a <= 8'h19)
		begin
			@(posedge clk);
			#1;
			reg_wr_en = 1'b1;
			reg_addr = a;
			reg_wdata = v;
			@(posedge clk);
			#1;
			reg_wr_en = 1'b0;
			reg_addr = ~a;
			reg_wdata = ~v;
		end
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		#1;
		reg_rd_en = 1'b1;
		reg_addr = a;
		@(posedge clk);
		#1;
		reg_rd_en = 1'b0;
		reg_addr = ~a;
		d = reg_rd_valid ? reg_rdata : 8'hXX;
	endtask : rd
endmodule : mrcr_host_model
`default_nettype wire

/* File: bench/mrcr_top_test.sv */
`timescale 1ns/10ps
`default_nettype none
module mrcr_top_test;
	import mrcr_pkg::*;
	logic         clk, rst_n, reg_wr_en, reg_rd_en, reg_rd_valid, duty_ctrl, ramp_busy;
	logic         bridge_command_source, bridge_enable_pwm_bit, bridge_phase_pwm_bit;
	logic         bridge_in1, bridge_in2, internal_pwm_active;
	logic [1:0]   bridge_input_pins;
	logic [7:0]   reg_addr, reg_wdata, reg_rdata, speed_voltage_setpoint, a, d, v;
	logic [7:0]   speed_scale_factor, inverse_resistance_param, back_emf_param;
	logic [10:0]  output_filter_cutoff;
	logic [13:0]  resistance_param_scale;
	logic [17:0]  back_emf_param_scale;
	mrcr_scheme_t scheme;
	logic [31:0]  seed = 32'd69332;
	logic [7:0]   shadow [12];
	int           n_fail = 0, n_compared = 0, hi, rises, p;
	localparam logic [7:0] RST [12] = '{8'h27, 8'hFF, 8'h00, 8'h01, 8'hFF, 8'h73,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h21, 8'h21};
	mrcr_top #(.INRUSH_US(3)) uut (.clk, .rst_n, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
		.reg_rdata, .reg_rd_valid, .bridge_command_source, .bridge_enable_pwm_bit,
		.bridge_phase_pwm_bit, .duty_ctrl, .bridge_input_pins, .bridge_in1, .bridge_in2,
		.internal_pwm_active, .scheme, .speed_voltage_setpoint, .ramp_busy, .speed_scale_factor,
		.output_filter_cutoff, .resistance_param_scale, .back_emf_param_scale,
		.inverse_resistance_param, .back_emf_param);
	mrcr_host_model host (.clk, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata,
		.reg_rd_valid);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	function automatic logic [31:0] f_res(input int c);
		return c == 0 ? 2 : c == 1 ? 64 : c == 2 ? 1024 : 8192;
	endfunction : f_res
	function automatic logic [31:0] f_bemf(input int c);
		return 24 << (c < 2 ? 8 + c : 10 + c);
	endfunction : f_bemf
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic put(input logic [7:0] ad, input logic [7:0] dd);
		host.wr(ad, dd);
		shadow[ad - 8'h0E] = dd & (ad == 8'h0E ? 8'h3F : 8'hFF);
	endtask : put
	task automatic rd_all(input logic [7:0] t [12]);
		for (int i = 0; i < 12; i++)
		begin
			host.rd(8'h0E + 8'(i), v);
			check(v, t[i]);
		end
		host.rd(8'h0D, v);
		check(v, 8'h00);
		host.rd(8'h1A, v);
		check(v, 8'h00);
	endtask : rd_all
	task automatic sample(input int n);
		logic q;
		hi = 0;
		rises = 0;
		q = bridge_in1;
		repeat (n)
		begin
			cyc(1);
			hi += bridge_in1;
			rises += bridge_in1 & ~q;
			q = bridge_in1;
		end
	endtask : sample
	task automatic finish_test();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : finish_test
	// ----------------------------------------
	// clock, watchdog, sequence
	// ----------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		#600_000;
		n_fail++;
		finish_test();
	end
	initial
	begin
		rst_n = 1'b0;
		{bridge_command_source, bridge_enable_pwm_bit, bridge_phase_pwm_bit, duty_ctrl} = 4'h0;
		bridge_input_pins = 2'h0;
		shadow = RST;
		cyc(4);
		rst_n = 1'b1;
		rd_all(RST);
		for (int k = 0; k < 4; k++)
		begin
			put(8'h0E, {3'h1, 2'(k), 1'b0, 2'(k)});
			put(8'h10, {2'(k), 6'h00});
			put(8'h13, {2'(k), 2'(k), 4'h3});
			cyc(3);
			check(scheme, k);
			check(speed_scale_factor, 16 << k);
			check(output_filter_cutoff, 250 * (k + 1));
			check(resistance_param_scale, f_res(k));
			check(back_emf_param_scale, f_bemf(k));
		end
		put(8'h0E, 8'hFF);
		host.rd(8'h0E, v);
		check(v, 8'h3F);
		repeat (40)
		begin
			a = 8'h0E + 8'(rnd() % 12);
			d = 8'(rnd());
			if (a == 8'h14 && d == 8'h00)
				d = 8'h01;
			put(a, d);
			host.rd(a, v);
			check(v, shadow[a - 8'h0E]);
		end
		bridge_command_source = 1'b1;
		repeat (8)
		begin
			{bridge_enable_pwm_bit, bridge_phase_pwm_bit} = 2'(rnd());
			cyc(2);
			check({bridge_in1, bridge_in2}, {bridge_enable_pwm_bit, bridge_phase_pwm_bit});
		end
		bridge_command_source = 1'b0;
		repeat (8)
		begin
			bridge_input_pins = 2'(rnd());
			cyc(4);
			check({bridge_in2, bridge_in1}, bridge_input_pins);
		end
		// ramp with soft start off, then on
		{bridge_command_source, bridge_enable_pwm_bit} = 2'h2;
		put(8'h0F, 8'h5A);
		put(8'h0E, 8'h10);
		cyc(4);
		check(speed_voltage_setpoint, 8'h00);
		bridge_enable_pwm_bit = 1'b1;
		cyc(3);
		check(speed_voltage_setpoint, 8'h5A);
		bridge_enable_pwm_bit = 1'b0;
		put(8'h0E, 8'h30);
		cyc(100);
		check(speed_voltage_setpoint, 8'h00);
		bridge_enable_pwm_bit = 1'b1;
		cyc(4);
		check(ramp_busy, 1'b1);
		check(speed_voltage_setpoint < 8'h5A, 1'b1);
		cyc(100);
		check(speed_voltage_setpoint, 8'h5A);
		check(ramp_busy, 1'b0);
		// programmed duty and both rates
		duty_ctrl = 1'b1;
		put(8'h0E, 8'h00);
		put(8'h10, 8'h00);
		cyc(3);
		check(internal_pwm_active, 1'b1);
		sample(300);
		check(hi, 0);
		put(8'h10, 8'h3F);
		cyc(3);
		sample(300);
		check(hi, 300);
		put(8'h10, 8'h20);
		for (int r = 0; r < 2; r++)
		begin
			p = MRCR_CLK_HZ / (r ? MRCR_PWM_SLOW_HZ : MRCR_PWM_FAST_HZ);
			put(8'h0E, {5'h00, 1'(r), 2'h0});
			cyc(4000);
			sample(8000);
			check(rises, 8000 / p);
			check(hi, (8000 / p) * ((32 * p + 62) / 63));
		end
		put(8'h0E, 8'h10);
		cyc(3);
		check(internal_pwm_active, 1'b0);
		rd_all(shadow);
		check(inverse_resistance_param, shadow[6]);
		check(back_emf_param, shadow[7]);
		rst_n = 1'b0;
		cyc(2);
		rst_n = 1'b1;
		rd_all(RST);
		finish_test();
	end
endmodule : mrcr_top_test
`default_nettype wire
